// file: cal_setup_unlock_regs.sv
// Bus slave with unlock-gated calibration and setup register bank.
`timescale 1ns/1ns
module cal_setup_unlock_regs
   import cal_setup_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic setup_mode_o,
   output logic cell2_pin_io_enable_o,
   output logic thermistor_pin_io_enable_o,
   output logic bias_ext_sel_o,
   output logic [3:0] bandgap_trim_o,
   output logic [5:0] reference_trim_o,
   output logic [6:0] main_oscillator_trim_o,
   output logic [4:0] aux_oscillator_trim_o
);
   typedef struct packed {
      bus_state_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic [7:0] tx;
      logic rw;
      logic ack;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic addr_vld;
      logic [7:0] addr_byte;
      logic setup;
      logic [6:0] own_addr;
      logic [3:0] bg;
      logic [5:0] ref_trim;
      logic cell2_io;
      logic therm_io;
      logic bias_sel;
      logic [6:0] mosc;
      logic [4:0] aosc;
   } main_state_s;

   localparam main_state_s MAIN_RST = '{
      st: ST_IDLE,
      cnt: 4'h0,
      sh: 8'h00,
      ptr: 8'h00,
      tx: 8'h00,
      rw: 1'b0,
      ack: 1'b0,
      scl_q: 1'b1,
      sda_q: 1'b1,
      sda_oe: 1'b0,
      addr_vld: 1'b0,
      addr_byte: 8'h00,
      setup: 1'b0,
      own_addr: RST_SLAVE_ADDR[7:ADDR_LSB],
      bg: RST_BANDGAP,
      ref_trim: RST_REF,
      cell2_io: 1'b0,
      therm_io: 1'b0,
      bias_sel: 1'b0,
      mosc: RST_MOSC,
      aosc: RST_AOSC
   };

   logic [1:0] rst_sync_r;
   logic rst_n;
   main_state_s s_r;
   main_state_s s_nxt;
   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic byte_end_c;
   logic addr_done_c;
   logic cmd_done_c;
   logic wr_fire_c;

   unlock_if u ();

   // Release of the reset passes two flip-flops before use.
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // True for the locations of the setup bank.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_SLAVE_ADDR) || (a == OFS_BANDGAP) ||
               (a == OFS_REF) || (a == OFS_MOSC) || (a == OFS_AOSC);
   endfunction : mapped

   // True for an address byte belonging to the unlock sequence.
   function automatic logic is_seq(input logic [7:0] a);
      is_seq = (a == SEQ_ADDR_1) || (a == SEQ_ADDR_2) ||
               (a == SEQ_ADDR_3);
   endfunction : is_seq

   // Read data; reserved bits read as zero.
   function automatic logic [7:0] rd_byte(input main_state_s s);
      rd_byte = 8'h00;
      if (s.setup) begin
         case (s.ptr)
            OFS_SLAVE_ADDR: rd_byte = {s.own_addr, 1'b0};
            OFS_BANDGAP: rd_byte = {4'h0, s.bg};
            OFS_REF: rd_byte = {s.cell2_io, s.therm_io, s.ref_trim};
            OFS_MOSC: rd_byte = {s.bias_sel, s.mosc};
            OFS_AOSC: rd_byte = {3'h0, s.aosc};
            default: rd_byte = 8'h00;
         endcase
      end
   endfunction : rd_byte

   // Bus conditions: data moving while the clock is high frames a message.
   assign start_c = s_r.scl_q && scl_i && s_r.sda_q && !sda_i;
   assign stop_c = s_r.scl_q && scl_i && !s_r.sda_q && sda_i;
   assign rise_c = !s_r.scl_q && scl_i;
   assign fall_c = s_r.scl_q && !scl_i;
   assign byte_end_c = fall_c && (s_r.cnt == BYTE_BITS);
   assign addr_done_c = byte_end_c && (s_r.st == ST_ADDR);
   assign cmd_done_c = byte_end_c && (s_r.st == ST_CMD);
   assign wr_fire_c = byte_end_c && (s_r.st == ST_WDATA) &&
                      s_r.setup && mapped(s_r.ptr);

   // Next state of the bus slave and the register bank.
   always_comb begin
      s_nxt = s_r;
      s_nxt.scl_q = scl_i;
      s_nxt.sda_q = sda_i;
      s_nxt.addr_vld = 1'b0;
      if (u.toggle) begin
         s_nxt.setup = !s_r.setup;
      end
      if (start_c) begin
         s_nxt.st = ST_ADDR;
         s_nxt.cnt = 4'h0;
         s_nxt.sda_oe = 1'b0;
      end else if (stop_c) begin
         s_nxt.st = ST_IDLE;
         s_nxt.sda_oe = 1'b0;
      end else if (rise_c) begin
         case (s_r.st)
            ST_ADDR, ST_CMD, ST_WDATA: begin
               s_nxt.sh = {s_r.sh[6:0], sda_i};
               s_nxt.cnt = s_r.cnt + 4'h1;
            end
            ST_RDATA: s_nxt.cnt = s_r.cnt + 4'h1;
            ST_RDATA_ACK: s_nxt.ack = !sda_i;
            default: ;
         endcase
      end else if (fall_c) begin
         case (s_r.st)
            ST_ADDR: begin
               if (byte_end_c) begin
                  // Every address reaches the detector; its own are refused.
                  s_nxt.addr_vld = 1'b1;
                  s_nxt.addr_byte = s_r.sh;
                  s_nxt.ack = (s_r.sh[7:ADDR_LSB] == s_r.own_addr) &&
                              !is_seq(s_r.sh);
                  s_nxt.sda_oe = s_nxt.ack;
                  s_nxt.rw = s_r.sh[0];
                  s_nxt.st = ST_ADDR_ACK;
                  s_nxt.cnt = 4'h0;
               end
            end
            ST_CMD: begin
               if (byte_end_c) begin
                  s_nxt.ack = s_r.setup && mapped(s_r.sh);
                  s_nxt.sda_oe = s_nxt.ack;
                  s_nxt.ptr = s_r.sh;
                  s_nxt.st = ST_CMD_ACK;
                  s_nxt.cnt = 4'h0;
               end
            end
            ST_WDATA: begin
               if (byte_end_c) begin
                  s_nxt.ack = wr_fire_c;
                  s_nxt.sda_oe = wr_fire_c;
                  s_nxt.st = ST_WDATA_ACK;
                  s_nxt.cnt = 4'h0;
               end
            end
            ST_RDATA: begin
               if (byte_end_c) begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = ST_RDATA_ACK;
                  s_nxt.cnt = 4'h0;
               end else begin
                  s_nxt.sda_oe = !s_r.tx[7];
                  s_nxt.tx = {s_r.tx[6:0], 1'b0};
               end
            end
            ST_ADDR_ACK, ST_RDATA_ACK: begin
               if (s_r.ack && (s_r.rw || s_r.st == ST_RDATA_ACK)) begin
                  s_nxt.tx = rd_byte(s_r);
                  s_nxt.sda_oe = !s_nxt.tx[7];
                  s_nxt.tx = {s_nxt.tx[6:0], 1'b0};
                  s_nxt.st = ST_RDATA;
               end else begin
                  s_nxt.sda_oe = 1'b0;
                  s_nxt.st = s_r.ack ? ST_CMD : ST_IDLE;
               end
               s_nxt.cnt = 4'h0;
            end
            ST_CMD_ACK: begin
               s_nxt.sda_oe = 1'b0;
               s_nxt.st = s_r.ack ? ST_WDATA : ST_IDLE;
            end
            default: begin
               s_nxt.sda_oe = 1'b0;
               s_nxt.st = ST_IDLE;
            end
         endcase
      end
      // Register writes land at the end of the data byte.
      if (wr_fire_c && !start_c && !stop_c) begin
         case (s_r.ptr)
            OFS_SLAVE_ADDR: s_nxt.own_addr = s_r.sh[7:ADDR_LSB];
            OFS_BANDGAP: s_nxt.bg = s_r.sh[BG_MSB:0];
            OFS_REF: begin
               s_nxt.cell2_io = s_r.sh[CELL2_IO_BIT];
               s_nxt.therm_io = s_r.sh[THERM_IO_BIT];
               s_nxt.ref_trim = s_r.sh[REF_MSB:0];
            end
            OFS_MOSC: begin
               s_nxt.bias_sel = s_r.sh[BIAS_SEL_BIT];
               s_nxt.mosc = s_r.sh[MOSC_MSB:0];
            end
            OFS_AOSC: s_nxt.aosc = s_r.sh[AOSC_MSB:0];
            default: ;
         endcase
      end
   end

   // All state of the slave; reset leaves setup mode off.
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= MAIN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   unlock_seq_detect detect (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .u(u.det)
   );

   // Detector feed comes straight from the state register.
   assign u.addr_valid = s_r.addr_vld;
   assign u.addr_byte = s_r.addr_byte;

   // The pin only ever pulls low.
   assign sda_o = 1'b0;
   assign sda_oe_o = s_r.sda_oe;
   assign setup_mode_o = s_r.setup;
   assign cell2_pin_io_enable_o = s_r.cell2_io;
   assign thermistor_pin_io_enable_o = s_r.therm_io;
   assign bias_ext_sel_o = s_r.bias_sel;
   assign bandgap_trim_o = s_r.bg;
   assign reference_trim_o = s_r.ref_trim;
   assign main_oscillator_trim_o = s_r.mosc;
   assign aux_oscillator_trim_o = s_r.aosc;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n);

   // Sequence bytes are never acknowledged.
   chk_seq_nack: assert property (
      addr_done_c && !start_c && !stop_c && is_seq(s_r.sh)
      |=> s_r.st == ST_ADDR_ACK && !s_r.sda_oe)
      else $error("Unlock address was acknowledged.");

   // The own address is acknowledged at the end of the byte.
   chk_own_ack: assert property (
      addr_done_c && !start_c && !stop_c && !is_seq(s_r.sh) &&
      s_r.sh[7:ADDR_LSB] == s_r.own_addr |=> s_r.sda_oe)
      else $error("Own address not acknowledged.");

   // Locked bank refuses every command byte.
   chk_locked_cmd: assert property (
      cmd_done_c && !start_c && !stop_c && !s_r.setup |=> !s_r.sda_oe)
      else $error("Command acknowledged while locked.");

   // Each toggle flips the mode and the mode moves only then.
   chk_mode_toggle: assert property (
      u.toggle |=> s_r.setup != $past(s_r.setup))
      else $error("Setup mode did not follow toggle.");

   chk_mode_steady: assert property (
      !u.toggle |=> $stable(s_r.setup))
      else $error("Setup mode moved without sequence.");

   // Reset leaves the mode off.
   chk_locked_reset: assert property (
      @(posedge clk_sys_i) disable iff (1'b0)
      !rst_n |=> !s_r.setup)
      else $error("Setup mode on after reset.");

   // Writes reach their fields one cycle after the data byte.
   chk_bg_write: assert property (
      wr_fire_c && !start_c && !stop_c && s_r.ptr == OFS_BANDGAP
      |=> bandgap_trim_o == $past(s_r.sh[BG_MSB:0]))
      else $error("Band gap trim not written.");

   chk_ref_write: assert property (
      wr_fire_c && !start_c && !stop_c && s_r.ptr == OFS_REF
      |=> {cell2_pin_io_enable_o, thermistor_pin_io_enable_o,
           reference_trim_o} == $past(s_r.sh))
      else $error("Reference trim register not written.");

   chk_mosc_write: assert property (
      wr_fire_c && !start_c && !stop_c && s_r.ptr == OFS_MOSC
      |=> {bias_ext_sel_o, main_oscillator_trim_o} == $past(s_r.sh))
      else $error("Main oscillator trim not written.");

   chk_aosc_write: assert property (
      wr_fire_c && !start_c && !stop_c && s_r.ptr == OFS_AOSC
      |=> aux_oscillator_trim_o == $past(s_r.sh[AOSC_MSB:0]))
      else $error("Auxiliary oscillator trim not written.");

   cover_enter_setup: cover property ($rose(s_r.setup));
   cover_leave_setup: cover property ($fell(s_r.setup));
   cover_reg_write: cover property (wr_fire_c);
   cover_reg_read: cover property (s_r.st == ST_RDATA_ACK);
endmodule : cal_setup_unlock_regs

// file: cal_setup_pkg.sv
// Constants and types shared by the calibration/setup register block.
package cal_setup_pkg;
   // Register locations of the setup bank.
   localparam logic [7:0] OFS_SLAVE_ADDR = 8'h80;
   localparam logic [7:0] OFS_BANDGAP = 8'h81;
   localparam logic [7:0] OFS_REF = 8'h82;
   localparam logic [7:0] OFS_MOSC = 8'h83;
   localparam logic [7:0] OFS_AOSC = 8'h86;
   // Address bytes of the unlock sequence, in order.
   localparam logic [7:0] SEQ_ADDR_1 = 8'h50;
   localparam logic [7:0] SEQ_ADDR_2 = 8'h52;
   localparam logic [7:0] SEQ_ADDR_3 = 8'h74;
   // Reset values; trims stand in for factory values.
   localparam logic [7:0] RST_SLAVE_ADDR = 8'h16;
   localparam logic [3:0] RST_BANDGAP = 4'h0;
   localparam logic [5:0] RST_REF = 6'h00;
   localparam logic [6:0] RST_MOSC = 7'h00;
   localparam logic [4:0] RST_AOSC = 5'h00;
   // Field positions.
   localparam int ADDR_LSB = 1;
   localparam int BG_MSB = 3;
   localparam int REF_MSB = 5;
   localparam int MOSC_MSB = 6;
   localparam int AOSC_MSB = 4;
   localparam int CELL2_IO_BIT = 7;
   localparam int THERM_IO_BIT = 6;
   localparam int BIAS_SEL_BIT = 7;
   // Bits in one bus byte.
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Bus slave states.
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
      ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
   } bus_state_e;
   // Unlock detector progress.
   typedef enum logic [1:0] {
      SEQ_NONE, SEQ_GOT1, SEQ_GOT2
   } seq_state_e;
endpackage : cal_setup_pkg

// file: unlock_if.sv
// Link between the bus slave and the unlock sequence detector.
`timescale 1ns/1ns
interface unlock_if;
   logic addr_valid;
   logic [7:0] addr_byte;
   logic toggle;
   modport ctrl (output addr_valid, output addr_byte, input toggle);
   modport det (input addr_valid, input addr_byte, output toggle);
endinterface : unlock_if

// file: unlock_seq_detect.sv
// Detector for the three-address sequence that toggles setup mode.
`timescale 1ns/1ns
module unlock_seq_detect
   import cal_setup_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   unlock_if.det u
);
   typedef struct packed {
      seq_state_e st;
      logic toggle;
   } det_state_s;

   localparam det_state_s DET_RST = '{st: SEQ_NONE, toggle: 1'b0};

   det_state_s s_r;
   det_state_s s_nxt;

   // Advance on each expected address byte, restart on anything else.
   always_comb begin
      s_nxt = s_r;
      s_nxt.toggle = 1'b0;
      if (u.addr_valid) begin
         case (s_r.st)
            SEQ_GOT1: begin
               if (u.addr_byte == SEQ_ADDR_2) begin
                  s_nxt.st = SEQ_GOT2;
               end else if (u.addr_byte == SEQ_ADDR_1) begin
                  s_nxt.st = SEQ_GOT1;
               end else begin
                  s_nxt.st = SEQ_NONE;
               end
            end
            SEQ_GOT2: begin
               if (u.addr_byte == SEQ_ADDR_3) begin
                  s_nxt.toggle = 1'b1;
                  s_nxt.st = SEQ_NONE;
               end else if (u.addr_byte == SEQ_ADDR_1) begin
                  s_nxt.st = SEQ_GOT1;
               end else begin
                  s_nxt.st = SEQ_NONE;
               end
            end
            default: begin
               if (u.addr_byte == SEQ_ADDR_1) begin
                  s_nxt.st = SEQ_GOT1;
               end else begin
                  s_nxt.st = SEQ_NONE;
               end
            end
         endcase
      end
   end

   // State register.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r <= DET_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign u.toggle = s_r.toggle;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   // A foreign byte part way through drops the progress.
   chk_seq_restart: assert property (
      u.addr_valid && s_r.st != SEQ_NONE && u.addr_byte != SEQ_ADDR_1 &&
      u.addr_byte != SEQ_ADDR_2 && u.addr_byte != SEQ_ADDR_3
      |=> s_r.st == SEQ_NONE && !s_r.toggle)
      else $error("Unlock detector did not restart.");

   // Three consecutive sequence bytes give exactly one toggle.
   chk_seq_third: assert property (
      u.addr_valid && u.addr_byte == SEQ_ADDR_1 ##[1:300]
      u.addr_valid && u.addr_byte == SEQ_ADDR_2 ##[1:300]
      u.addr_valid && u.addr_byte == SEQ_ADDR_3 |=> s_r.toggle
      or !$past(s_r.st == SEQ_GOT2))
      else $error("Complete sequence gave no toggle.");

   cover_seq_toggle: cover property (s_r.toggle);
endmodule : unlock_seq_detect

// file: smbus_host_model.sv
// Behavioural SMBus host master that drives the bus and reports results.
`timescale 1ns/1ns
module smbus_host_model (
   input wire logic clk_sys_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o,
   output logic res_valid_o,
   output logic [7:0] res_o
);
   // The bus starts idle with both lines released high.
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
      res_valid_o = 1'b0;
      res_o = 8'h00;
   end

   // Host signals only change at falling clock edges.
   task automatic w(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask : w

   // One bit slot; SDA moves only while SCL is low.
   task automatic bit_xfer(input logic drive_low, output logic seen);
      w(2);
      sda_oe_o = drive_low;
      w(3);
      scl_o = 1'b1;
      w(2);
      seen = sda_i;
      w(2);
      scl_o = 1'b0;
   endtask : bit_xfer

   // Sends eight bits MSB first and samples the slave acknowledge.
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(~b[i], seen);
      end
      bit_xfer(1'b0, seen);
      ack = ~seen;
   endtask : send_byte

   // Receives eight bits and answers with a master ACK or NACK.
   task automatic recv_byte(input logic nack, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b0, seen);
         b[i] = seen;
      end
      bit_xfer(~nack, seen);
   endtask : recv_byte

   // Start or repeated start: SDA falls while SCL is high.
   task automatic start_cond();
      w(2);
      sda_oe_o = 1'b0;
      w(2);
      scl_o = 1'b1;
      w(3);
      sda_oe_o = 1'b1;
      w(3);
      scl_o = 1'b0;
   endtask : start_cond

   // Stop: SDA rises while SCL is high, then the bus rests.
   task automatic stop_cond();
      w(2);
      sda_oe_o = 1'b1;
      w(3);
      scl_o = 1'b1;
      w(3);
      sda_oe_o = 1'b0;
      w(4);
   endtask : stop_cond

   // Hands one result to the bench for a single clock.
   task automatic report(input logic [7:0] v);
      res_o = v;
      res_valid_o = 1'b1;
      w(1);
      res_valid_o = 1'b0;
   endtask : report

   // Address-only transaction; reports the acknowledge bit.
   task automatic addr_only(input logic [7:0] a);
      logic ack;
      start_cond();
      send_byte(a, ack);
      stop_cond();
      report({7'h00, ack});
   endtask : addr_only

   // Register write; reports the address, command and data acks.
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] cmd,
                            input logic [7:0] d);
      logic a0, a1, a2;
      start_cond();
      send_byte({dev, 1'b0}, a0);
      send_byte(cmd, a1);
      send_byte(d, a2);
      stop_cond();
      report({5'h00, a0, a1, a2});
   endtask : write_reg

   // Register read with repeated start; reports the data byte.
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] cmd);
      logic a0;
      logic [7:0] d;
      start_cond();
      send_byte({dev, 1'b0}, a0);
      send_byte(cmd, a0);
      start_cond();
      send_byte({dev, 1'b1}, a0);
      recv_byte(1'b1, d);
      stop_cond();
      report(d);
   endtask : read_reg
endmodule : smbus_host_model

// file: cal_setup_unlock_regs_tb_top.sv
// Self-checking bench for the unlock-gated setup register block.
`timescale 1ns/1ns
module cal_setup_unlock_regs_tb_top
   import cal_setup_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic scl, host_oe, res_valid, sda_oe, setup_mode;
   logic cell2_io, therm_io, bias_sel;
   logic [3:0] bg;
   logic [5:0] ref_t;
   logic [6:0] mosc;
   logic [4:0] aosc;
   logic [7:0] res;
   logic [7:0] r = 8'h09;
   logic [7:0] exp_q[$];
   logic [7:0] regs [4] = '{OFS_BANDGAP, OFS_REF, OFS_MOSC, OFS_AOSC};
   logic [7:0] vals [4];
   int mismatches = 0;
   int n_compared = 0;
   // The pulled-up data wire is low while either party drives it.
   wire sda_w = ~(host_oe | sda_oe);

   always #4 clk_sys = ~clk_sys;

   cal_setup_unlock_regs DUT (.clk_sys_i(clk_sys), .nrst_i(rst_n),
      .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
      .setup_mode_o(setup_mode), .cell2_pin_io_enable_o(cell2_io),
      .thermistor_pin_io_enable_o(therm_io), .bias_ext_sel_o(bias_sel),
      .bandgap_trim_o(bg), .reference_trim_o(ref_t),
      .main_oscillator_trim_o(mosc), .aux_oscillator_trim_o(aosc));

   smbus_host_model host (.clk_sys_i(clk_sys), .sda_i(sda_w),
      .scl_o(scl), .sda_oe_o(host_oe), .res_valid_o(res_valid),
      .res_o(res));

   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction : lfsr_next

   function automatic logic [7:0] field_mask(input logic [7:0] cmd);
      case (cmd)
         OFS_SLAVE_ADDR: return 8'hFE;
         OFS_BANDGAP: return 8'h0F;
         OFS_AOSC: return 8'h1F;
         default: return 8'hFF;
      endcase
   endfunction : field_mask

   // Gathers the output pins of one register into its byte layout.
   function automatic logic [7:0] port_view(input logic [7:0] cmd);
      case (cmd)
         OFS_BANDGAP: return {4'h0, bg};
         OFS_REF: return {cell2_io, therm_io, ref_t};
         OFS_MOSC: return {bias_sel, mosc};
         default: return {3'h0, aosc};
      endcase
   endfunction : port_view

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out();
      if (exp_q.size() != 0) begin
         mismatches++;
      end
      $display("checks %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   // Each reported bus result is matched with the oldest note.
   always @(posedge clk_sys) begin
      if (res_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("extra result", {1'b1, res[6:0]}, {1'b0, res[6:0]});
         end else begin
            check("bus result", res, exp_q.pop_front());
         end
      end
   end

   task automatic send_seq(input logic [7:0] a);
      exp_q.push_back(8'h00);
      host.addr_only(a);
   endtask : send_seq

   task automatic wr(input logic [6:0] dev, input logic [7:0] cmd,
                     input logic [7:0] d, input logic [7:0] acks);
      exp_q.push_back(acks);
      host.write_reg(dev, cmd, d);
   endtask : wr

   task automatic unlock();
      send_seq(SEQ_ADDR_1);
      send_seq(SEQ_ADDR_2);
      send_seq(SEQ_ADDR_3);
   endtask : unlock

   // Main sequence: lock, unlock, register traffic, relock and reset.
   initial begin
      logic [6:0] own;
      logic [7:0] d;
      own = RST_SLAVE_ADDR[7:1];
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("setup after reset", setup_mode, 8'h00);
      for (int k = 0; k < 4; k++) begin
         check("reset view", port_view(regs[k]), 8'h00);
      end
      wr(own, OFS_BANDGAP, 8'h05, 8'h04);
      check("locked write", port_view(OFS_BANDGAP), 8'h00);
      send_seq(SEQ_ADDR_1);
      send_seq(SEQ_ADDR_2);
      send_seq(8'h30);
      send_seq(SEQ_ADDR_3);
      check("broken sequence", setup_mode, 8'h00);
      send_seq(SEQ_ADDR_1);
      unlock();
      check("setup entered", setup_mode, 8'h01);
      for (int p = 0; p < 2; p++) begin
         for (int k = 0; k < 4; k++) begin
            if (p == 0) begin
               r = lfsr_next(r);
               vals[k] = r;
            end
            d = (p == 0) ? vals[k] : ~vals[k];
            wr(own, regs[k], d, 8'h07);
            d = d & field_mask(regs[k]);
            check("pin view", port_view(regs[k]), d);
            exp_q.push_back(d);
            host.read_reg(own, regs[k]);
         end
      end
      r = lfsr_next(r);
      d = {1'b1, r[6:0]};
      wr(own, OFS_SLAVE_ADDR, d, 8'h07);
      own = d[7:1];
      exp_q.push_back(d & 8'hFE);
      host.read_reg(own, OFS_SLAVE_ADDR);
      exp_q.push_back(8'h00);
      host.addr_only({RST_SLAVE_ADDR[7:1], 1'b0});
      unlock();
      check("setup left", setup_mode, 8'h00);
      wr(own, OFS_AOSC, 8'h1F, 8'h04);
      check("relocked", port_view(OFS_AOSC), ~vals[3] & 8'h1F);
      unlock();
      check("setup again", setup_mode, 8'h01);
      rst_n = 1'b0;
      repeat (3) @(negedge clk_sys);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_sys);
      check("setup after second reset", setup_mode, 8'h00);
      exp_q.push_back(8'h01);
      host.addr_only({RST_SLAVE_ADDR[7:1], 1'b0});
      close_out();
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      close_out();
   end
endmodule : cal_setup_unlock_regs_tb_top
